/* rtl/spf_baud_gen.sv */
// Baud down-counter producing one tick each time it reaches zero.
// Assumes reload is a one-cycle pulse from a divisor low byte write.
`timescale 1ns/100ps
module spf_baud_gen #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Control
    input  wire logic [W-1:0] divisor,
    input  wire logic         reload,
    // Tick out
    output logic              tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } spf_baud_t;

    spf_baud_t s_r;
    spf_baud_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = (s_r.cnt == '0);                              // R19
        if (reload || s_r.cnt == '0) begin
            s_nxt.cnt = divisor;                                   // R19
        end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule // spf_baud_gen

/* rtl/spf_host_ctrl.sv */
// Host end: APB slave that turns commands into serial port register accesses.
// Assumes the device answers a read with data one cycle after the select.
`timescale 1ns/100ps
module spf_host_ctrl (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device register port
    spf_link_if.host         bus
);
    typedef enum logic [3:0] {
        H_IDLE, H_RAW_A, H_RAW_D, H_POLL_A, H_POLL_D,
        H_CB_A, H_CB_D, H_WRB, H_DAT
    } spf_hstate_t;

    typedef struct packed {
        spf_hstate_t state;
        logic        busy;
        logic [8:0]  sendWord;
        logic [7:0]  lastRead;
        logic        syncSel;
        logic        gie;
        logic        sel;
        logic        wr;
        logic [2:0]  addr;
        logic [7:0]  wdata;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } spf_host_t;

    spf_host_t   s_r;
    spf_host_t   s_nxt;
    logic        apbWr;
    logic        setup;
    logic        mapped;
    logic [2:0]  cAddr;
    logic [7:0]  cData;

    assign apbWr  = psel & penable & s_r.pready & pwrite;
    assign setup  = psel & ~penable;
    assign mapped = paddr == spf_pkg::APB_CMD || paddr == spf_pkg::APB_STAT
                    || paddr == spf_pkg::APB_GIE;
    assign cAddr  = pwdata[spf_pkg::CMD_ADDR_LSB +: 3];
    assign cData  = pwdata[7:0];

    always_comb begin
        s_nxt         = s_r;
        s_nxt.sel     = 1'b0;
        s_nxt.pready  = setup;
        s_nxt.pslverr = setup & ~mapped;
        if (setup) begin
            unique case (paddr)
                spf_pkg::APB_STAT: s_nxt.prdata = {13'h0, bus.irqTxEmpty,
                    bus.irqTxComplete, bus.irqRxComplete, s_r.lastRead, 7'h0, s_r.busy};
                spf_pkg::APB_GIE:  s_nxt.prdata = {31'h0, s_r.gie};
                default:           s_nxt.prdata = 32'h0;
            endcase
        end
        if (apbWr && paddr == spf_pkg::APB_GIE) begin
            s_nxt.gie = pwdata[0];
        end
        unique case (s_r.state)
            H_IDLE: begin
                if (apbWr && paddr == spf_pkg::APB_CMD) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.sel  = 1'b1;
                    unique case (pwdata[spf_pkg::CMD_OP_LSB +: 2])
                        spf_pkg::OP_SEND: begin
                            s_nxt.sendWord = pwdata[8:0];
                            s_nxt.wr       = 1'b0;
                            s_nxt.addr     = spf_pkg::REG_STATUS_A;         // R1
                            s_nxt.state    = H_POLL_A;
                        end
                        spf_pkg::OP_READ: begin
                            s_nxt.wr    = 1'b0;
                            s_nxt.addr  = cAddr;
                            s_nxt.state = H_RAW_A;
                        end
                        default: begin
                            s_nxt.wr    = 1'b1;
                            s_nxt.addr  = cAddr;
                            s_nxt.wdata = cData;
                            s_nxt.state = H_RAW_A;
                            if (cAddr == spf_pkg::REG_CONTROL_C) begin
                                s_nxt.syncSel = cData[spf_pkg::CC_SYNC];
                            end
                            if (cAddr == spf_pkg::REG_STATUS_A) begin
                                s_nxt.wdata = cData & ~spf_pkg::STATUS_A_W0; // R12
                                if (s_r.syncSel) begin
                                    s_nxt.wdata[spf_pkg::ST_U2X] = 1'b0;    // R13
                                end
                            end
                        end
                    endcase
                end
            end
            H_RAW_A: s_nxt.state = H_RAW_D;
            H_RAW_D: begin
                if (!s_r.wr) begin
                    s_nxt.lastRead = bus.regRdata;
                end
                s_nxt.busy  = 1'b0;
                s_nxt.state = H_IDLE;
            end
            H_POLL_A: s_nxt.state = H_POLL_D;
            H_POLL_D: begin
                s_nxt.sel = 1'b1;
                if (bus.regRdata[spf_pkg::ST_UDRE]) begin                  // R1
                    s_nxt.addr  = spf_pkg::REG_CONTROL_B;
                    s_nxt.state = H_CB_A;
                end else begin
                    s_nxt.state = H_POLL_A;
                end
            end
            H_CB_A: s_nxt.state = H_CB_D;
            H_CB_D: begin
                s_nxt.sel   = 1'b1;
                s_nxt.wr    = 1'b1;
                s_nxt.wdata = {bus.regRdata[7:1], s_r.sendWord[8]};        // R2
                s_nxt.state = H_WRB;
            end
            H_WRB: begin
                s_nxt.sel   = 1'b1;
                s_nxt.addr  = spf_pkg::REG_DATA;
                s_nxt.wdata = s_r.sendWord[7:0];                           // R2
                s_nxt.state = H_DAT;
            end
            H_DAT: begin
                s_nxt.busy  = 1'b0;
                s_nxt.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r       <= '0;
            s_r.state <= H_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata          = s_r.prdata;
    assign pready          = s_r.pready;
    assign pslverr         = s_r.pslverr;
    assign bus.regSel      = s_r.sel;
    assign bus.regWrite    = s_r.wr;
    assign bus.regAddr     = s_r.addr;
    assign bus.regWdata    = s_r.wdata;
    assign bus.globalIrqEn = s_r.gie;
endmodule // spf_host_ctrl

/* rtl/spf_link_if.sv */
// Register port between the serial port device and its host controller.
// Assumes both ends run on one clock; the bench instantiates it.
`timescale 1ns/100ps
interface spf_link_if;
    logic       regSel;
    logic       regWrite;
    logic [2:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic       globalIrqEn;
    logic       irqRxComplete;
    logic       irqTxComplete;
    logic       irqTxEmpty;

    modport dev (
        input  regSel, regWrite, regAddr, regWdata, globalIrqEn,
        output regRdata, irqRxComplete, irqTxComplete, irqTxEmpty
    );
    modport host (
        output regSel, regWrite, regAddr, regWdata, globalIrqEn,
        input  regRdata, irqRxComplete, irqTxComplete, irqTxEmpty
    );
endinterface // spf_link_if

/* rtl/spf_pkg.sv */
// Constants shared by the serial port device end and its host controller end.
// Assumes both ends use the same register index map and field layout.
package spf_pkg;
    // ------------
    // Device register indices
    // ------------
    localparam logic [2:0] REG_DATA      = 3'h0;
    localparam logic [2:0] REG_STATUS_A  = 3'h1;
    localparam logic [2:0] REG_CONTROL_B = 3'h2;
    localparam logic [2:0] REG_CONTROL_C = 3'h3;
    localparam logic [2:0] REG_BAUD_LOW  = 3'h4;
    localparam logic [2:0] REG_BAUD_HIGH = 3'h5;
    // ------------
    // Field positions
    // ------------
    localparam int ST_RXC   = 7;
    localparam int ST_TXC   = 6;
    localparam int ST_UDRE  = 5;
    localparam int ST_FE    = 4;
    localparam int ST_DOR   = 3;
    localparam int ST_UPE   = 2;
    localparam int ST_U2X   = 1;
    localparam int ST_MPCM  = 0;
    localparam int CB_RXCIE = 7;
    localparam int CB_TXCIE = 6;
    localparam int CB_UDRIE = 5;
    localparam int CB_RXEN  = 4;
    localparam int CB_TXEN  = 3;
    localparam int CB_NINE  = 2;
    localparam int CB_RXB8  = 1;
    localparam int CB_TX_NINTH_BIT  = 0;
    localparam int CC_SYNC  = 6;
    localparam int CC_PARH  = 5;
    localparam int CC_PODD  = 4;
    // ------------
    // Reset values, masks and timing
    // ------------
    localparam logic [7:0]  CONTROL_RST  = 8'h00;
    localparam logic [11:0] BAUD_RST     = 12'h000;
    localparam logic [7:0]  STATUS_A_W0  = 8'h3c;
    localparam logic [4:0]  OVS_NORMAL   = 5'h10;
    localparam logic [4:0]  OVS_DOUBLE   = 5'h08;
    // ------------
    // Host controller APB map and command fields
    // ------------
    localparam logic [11:0] APB_CMD      = 12'h000;
    localparam logic [11:0] APB_STAT     = 12'h004;
    localparam logic [11:0] APB_GIE      = 12'h008;
    localparam int          CMD_OP_LSB   = 16;
    localparam int          CMD_ADDR_LSB = 12;
    localparam logic [1:0]  OP_WRITE     = 2'h0;
    localparam logic [1:0]  OP_READ      = 2'h1;
    localparam logic [1:0]  OP_SEND      = 2'h2;
endpackage

/* rtl/spf_uart_dev.sv */
// Serial port device end: register file, transmitter, receiver, flags.
// Assumes the host obeys the register port timing of spf_link_if.
// Operation
// [R1] Host waits for empty buffer before loading
// [R2] Host sets ninth bit before data write
// [R3] Data write loads the transmit buffer
// [R4] Ninth bit marks address frames
// [R5] Empty and complete flags each raise interrupts
// [R6] Empty flag high exactly while buffer vacant
// [R7] Empty interrupt held while enabled and empty
// [R8] Data write clears empty; reset sets it
// [R9] Frame error from first stop bit
// [R10] Overrun on full buffer plus new start
// [R11] Parity error when parity checking enabled
// [R12] Host writes zeros to status flag bits
// [R13] Double speed affects asynchronous operation only
// [R14] Double speed changes divisor 16 to 8
// [R15] Multi-node mode drops non-address frames
// [R16] Transmitter ignores multi-node mode
// [R17] Receive interrupt needs enable, global, flag
// [R18] Transmit interrupt needs enable, global, flag
// [R19] Baud counter reloads at zero or low write
// [R20] Complete flag after stop with empty buffer
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module spf_uart_dev #(
    parameter int BAUD_W = 12
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Register port
    spf_link_if.dev   bus,
    // Serial line
    input  wire logic rxd,
    output logic      txd
);
    typedef struct packed {
        logic [7:0]        ctrlB;
        logic [7:0]        ctrlC;
        logic              u2x;
        logic              mpcm;
        logic [BAUD_W-1:0] baud;
        logic [8:0]        txBuf;
        logic              txEmpty;
        logic              txc;
        logic              txBusy;
        logic [11:0]       txFrame;
        logic [3:0]        txBits;
        logic [4:0]        txSub;
        logic              txd;
        logic              rxBusy;
        logic [4:0]        rxSub;
        logic [3:0]        rxBits;
        logic [10:0]       rxShift;
        logic              rxHeld;
        logic [10:0]       heldWord;
        logic [1:0][10:0]  fifo;
        logic [1:0]        fifoCnt;
        logic              dor;
        logic [7:0]        rdata;
        logic              irqRx;
        logic              irqTx;
        logic              irqEmpty;
    } spf_dev_t;

    spf_dev_t    s_r;
    spf_dev_t    s_nxt;
    logic        tick;
    logic        wrEn;
    logic        rdEn;
    logic        baudReload;
    logic        nine;
    logic        parEn;
    logic        rxDone;
    logic        rxMark;
    logic        rxc;
    logic [4:0]  ovs;
    logic [3:0]  nBits;
    logic [11:0] frameNew;
    logic [10:0] aligned;
    logic [10:0] rxWord;

    assign wrEn       = bus.regSel & bus.regWrite;
    assign rdEn       = bus.regSel & ~bus.regWrite;
    assign baudReload = wrEn && bus.regAddr == spf_pkg::REG_BAUD_LOW;

    spf_baud_gen #(.W(BAUD_W)) baudGen (
        .clk     (clk),
        .srst    (srst),
        .divisor (s_nxt.baud),
        .reload  (baudReload),
        .tick    (tick)
    );

    always_comb begin
        s_nxt    = s_r;
        rxDone   = 1'b0;
        nine     = s_r.ctrlB[spf_pkg::CB_NINE];
        parEn    = s_r.ctrlC[spf_pkg::CC_PARH];
        rxc      = (s_r.fifoCnt != 2'h0);
        nBits    = 4'h9 + {3'h0, nine} + {3'h0, parEn};
        // ------------
        // Oversampling divisor
        // ------------
        ovs = (s_r.u2x && !s_r.ctrlC[spf_pkg::CC_SYNC]) ?
              spf_pkg::OVS_DOUBLE : spf_pkg::OVS_NORMAL;     // R13 R14
        // ------------
        // Outgoing frame: data, ninth bit, parity, stop ones
        // ------------
        frameNew      = 12'hfff;
        frameNew[7:0] = s_r.txBuf[7:0];
        if (nine) begin
            frameNew[8] = s_r.txBuf[8];                            // R4
        end
        if (parEn) begin
            frameNew[4'h8 + {3'h0, nine}] = ^s_r.txBuf[7:0] ^ (nine & s_r.txBuf[8])
                                            ^ s_r.ctrlC[spf_pkg::CC_PODD];
        end
        // ------------
        // Register reads and their side effects
        // ------------
        if (rdEn) begin
            unique case (bus.regAddr)
                spf_pkg::REG_DATA: begin
                    s_nxt.rdata = s_r.fifo[0][7:0];
                    if (rxc) begin
                        s_nxt.fifo[0] = s_r.fifo[1];
                        s_nxt.fifoCnt = s_r.fifoCnt - 2'h1;
                        s_nxt.dor     = 1'b0;                      // R9 R10 R11
                        if (s_r.rxHeld) begin
                            s_nxt.fifo[s_nxt.fifoCnt[0]] = s_r.heldWord;
                            s_nxt.fifoCnt                = s_r.fifoCnt;
                            s_nxt.rxHeld                 = 1'b0;
                        end
                    end
                end
                spf_pkg::REG_STATUS_A: s_nxt.rdata = {rxc, s_r.txc, s_r.txEmpty,
                    rxc & s_r.fifo[0][9], s_r.dor, rxc & s_r.fifo[0][10],
                    s_r.u2x, s_r.mpcm};                            // R5 R9 R10 R11
                spf_pkg::REG_CONTROL_B: s_nxt.rdata = {s_r.ctrlB[7:2],
                    rxc & s_r.fifo[0][8], s_r.ctrlB[0]};
                spf_pkg::REG_CONTROL_C: s_nxt.rdata = s_r.ctrlC;
                spf_pkg::REG_BAUD_LOW:  s_nxt.rdata = s_r.baud[7:0];
                spf_pkg::REG_BAUD_HIGH: s_nxt.rdata = 8'(s_r.baud[BAUD_W-1:8]);
                default:                s_nxt.rdata = 8'h00;
            endcase
        end
        // ------------
        // Transmitter; the multi-node bit is never consulted here
        // ------------
        // The write-one clear of txc comes first so a set in the same cycle wins.
        if (wrEn && bus.regAddr == spf_pkg::REG_STATUS_A && bus.regWdata[spf_pkg::ST_TXC]) begin
            s_nxt.txc = 1'b0;
        end
        if (tick && s_r.txBusy) begin                              // R16
            if (s_r.txSub == ovs - 5'h01) begin
                s_nxt.txSub = 5'h00;
                if (s_r.txBits == 4'h0) begin
                    s_nxt.txBusy = 1'b0;
                    s_nxt.txd    = 1'b1;
                    if (s_r.txEmpty) begin
                        s_nxt.txc = 1'b1;                          // R20
                    end
                end else begin
                    s_nxt.txd     = s_r.txFrame[0];
                    s_nxt.txFrame = {1'b1, s_r.txFrame[11:1]};
                    s_nxt.txBits  = s_r.txBits - 4'h1;
                end
            end else begin
                s_nxt.txSub = s_r.txSub + 5'h01;
            end
        end
        if (!s_r.txBusy && !s_r.txEmpty && s_r.ctrlB[spf_pkg::CB_TXEN]) begin
            s_nxt.txBusy  = 1'b1;
            s_nxt.txd     = 1'b0;
            s_nxt.txFrame = frameNew;
            s_nxt.txBits  = nBits;
            s_nxt.txSub   = 5'h00;
            s_nxt.txEmpty = 1'b1;                                  // R6
        end
        // ------------
        // Register writes
        // ------------
        if (wrEn) begin
            unique case (bus.regAddr)
                spf_pkg::REG_DATA: begin
                    s_nxt.txBuf   = {s_r.ctrlB[spf_pkg::CB_TX_NINTH_BIT], bus.regWdata}; // R3
                    s_nxt.txEmpty = 1'b0;                          // R6 R8
                end
                spf_pkg::REG_STATUS_A: begin
                    s_nxt.u2x  = bus.regWdata[spf_pkg::ST_U2X];
                    s_nxt.mpcm = bus.regWdata[spf_pkg::ST_MPCM];
                end
                spf_pkg::REG_CONTROL_B: s_nxt.ctrlB = {bus.regWdata[7:2], 1'b0,
                                                       bus.regWdata[0]};
                spf_pkg::REG_CONTROL_C: s_nxt.ctrlC = bus.regWdata;
                spf_pkg::REG_BAUD_LOW:  s_nxt.baud[7:0] = bus.regWdata;  // R19
                spf_pkg::REG_BAUD_HIGH: s_nxt.baud[BAUD_W-1:8] = bus.regWdata[BAUD_W-9:0];
                default: ;
            endcase
        end
        // ------------
        // Receiver
        // ------------
        if (tick && s_r.ctrlB[spf_pkg::CB_RXEN]) begin
            if (!s_r.rxBusy) begin
                if (!rxd) begin
                    s_nxt.rxBusy = 1'b1;
                    s_nxt.rxSub  = 5'h00;
                    s_nxt.rxBits = 4'h0;
                    if (s_r.fifoCnt == 2'h2 && s_r.rxHeld) begin
                        s_nxt.dor = 1'b1;                          // R10
                    end
                end
            end else begin
                s_nxt.rxSub = (s_r.rxSub == ovs - 5'h01) ? 5'h00 : s_r.rxSub + 5'h01;
                if (s_r.rxSub == (ovs >> 1) - 5'h01) begin
                    s_nxt.rxBits = s_r.rxBits + 4'h1;
                    if (s_r.rxBits == 4'h0) begin
                        s_nxt.rxBusy = ~rxd;
                    end else begin
                        s_nxt.rxShift = {rxd, s_r.rxShift[10:1]};
                    end
                    if (s_r.rxBits == nBits) begin
                        s_nxt.rxBusy = 1'b0;
                        rxDone       = 1'b1;
                    end
                end
            end
        end
        aligned = s_nxt.rxShift >> (4'hb - nBits);
        rxMark  = nine ? aligned[8] : aligned[nBits - 4'h1];       // R4
        rxWord  = {parEn & (^aligned[7:0] ^ (nine & aligned[8])
                   ^ s_r.ctrlC[spf_pkg::CC_PODD] ^ aligned[4'h8 + {3'h0, nine}]), // R11
                   ~aligned[nBits - 4'h1],                         // R9
                   nine & aligned[8], aligned[7:0]};
        if (rxDone && !(s_r.mpcm && !rxMark)) begin                // R15
            if (s_nxt.fifoCnt != 2'h2) begin
                s_nxt.fifo[s_nxt.fifoCnt[0]] = rxWord;
                s_nxt.fifoCnt                = s_nxt.fifoCnt + 2'h1;
            end else if (!s_nxt.rxHeld) begin
                s_nxt.rxHeld   = 1'b1;
                s_nxt.heldWord = rxWord;
            end
        end
        // ------------
        // Interrupt requests
        // ------------
        s_nxt.irqRx    = s_r.ctrlB[spf_pkg::CB_RXCIE] & bus.globalIrqEn & rxc;       // R17
        s_nxt.irqTx    = s_r.ctrlB[spf_pkg::CB_TXCIE] & bus.globalIrqEn & s_r.txc;   // R5 R18
        s_nxt.irqEmpty = s_r.ctrlB[spf_pkg::CB_UDRIE] & bus.globalIrqEn
                         & s_r.txEmpty;                            // R5 R7
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r         <= '0;
            s_r.ctrlB   <= spf_pkg::CONTROL_RST;
            s_r.ctrlC   <= spf_pkg::CONTROL_RST;
            s_r.baud    <= BAUD_W'(spf_pkg::BAUD_RST);
            s_r.txEmpty <= 1'b1;                                   // R8
            s_r.txd     <= 1'b1;
            s_r.txFrame <= 12'hfff;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign txd               = s_r.txd;
    assign bus.regRdata      = s_r.rdata;
    assign bus.irqRxComplete = s_r.irqRx;
    assign bus.irqTxComplete = s_r.irqTx;
    assign bus.irqTxEmpty    = s_r.irqEmpty;
endmodule // spf_uart_dev

/* verif/spf_link_sva.sv */
// Checker of the register port joining the serial port device and host.
// Assumes one clock and a synchronous, active high reset.
`timescale 1ns/100ps
module spf_link_sva (
    // Clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // Register port
    input wire logic       regSel,
    input wire logic       regWrite,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Interrupts
    input wire logic       globalIrqEn,
    input wire logic       irqRxComplete,
    input wire logic       irqTxComplete,
    input wire logic       irqTxEmpty
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic wrA, wrB, wrC, wrD;
    logic rdSt_r, seen_r, ieOn_r, sync_r, sent_r;
    assign wrA = regSel && regWrite && regAddr == spf_pkg::REG_STATUS_A;
    assign wrB = regSel && regWrite && regAddr == spf_pkg::REG_CONTROL_B;
    assign wrC = regSel && regWrite && regAddr == spf_pkg::REG_CONTROL_C;
    assign wrD = regSel && regWrite && regAddr == spf_pkg::REG_DATA;
    always_ff @(posedge clk) begin
        rdSt_r <= regSel && !regWrite && regAddr == spf_pkg::REG_STATUS_A;
        seen_r <= (srst || wrD) ? 1'b0 : (seen_r || (rdSt_r && regRdata[spf_pkg::ST_UDRE]));
        ieOn_r <= srst ? 1'b0 : (wrB ? regWdata[spf_pkg::CB_UDRIE] : ieOn_r);
        sync_r <= srst ? 1'b0 : (wrC ? regWdata[spf_pkg::CC_SYNC] : sync_r);
        sent_r <= srst ? 1'b0 : (sent_r || wrD);
    end
    rx_irq_gate_a: assert property (!$past(globalIrqEn) |-> !irqRxComplete)
        else $error("receive interrupt without global enable");
    tx_irq_gate_a: assert property (!$past(globalIrqEn) |-> !irqTxComplete)
        else $error("transmit interrupt without global enable");
    empty_irq_gate_a: assert property (!$past(globalIrqEn) |-> !irqTxEmpty)
        else $error("empty interrupt without global enable");
    empty_at_reset_a: assert property ($past(ieOn_r) && $past(ieOn_r, 2) && !sent_r
        && $past(globalIrqEn) && $past(globalIrqEn, 2) |-> irqTxEmpty)
        else $error("empty interrupt missing before first load");
    flag_zero_wr_a: assert property (wrA |-> (regWdata & spf_pkg::STATUS_A_W0) == 8'h00)
        else $error("status write carries nonzero flag bits");
    sync_no_dbl_a: assert property (wrA && sync_r |-> !regWdata[spf_pkg::ST_U2X])
        else $error("double speed written in synchronous mode");
    ninth_first_a: assert property (wrD |-> $past(wrB))
        else $error("data write not preceded by control write");
    poll_first_a: assert property (wrD |-> seen_r)
        else $error("data written without seeing empty buffer");
    cover property (irqTxEmpty);
    cover property (irqRxComplete);
    cover property (wrD);
endmodule // spf_link_sva

/* verif/test_serial_port_flags_and_control.sv */
// Bench driving the host controller over APB, device line looped back.
// Assumes the design ends of rtl/ and the checker of verif/.
`timescale 1ns/100ps
module test_serial_port_flags_and_control;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv, seed = 32'h20;
    logic        pready, pslverr, line;
    int          bad_count = 0, n_compared = 0;
    spf_link_if lnk ();
    spf_uart_dev u_spf_uart_dev (.clk(clk), .srst(srst), .bus(lnk), .rxd(line), .txd(line));
    spf_host_ctrl u_spf_host_ctrl (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(lnk));
    spf_link_sva chk (.clk(clk), .srst(srst), .regSel(lnk.regSel), .regWrite(lnk.regWrite),
        .regAddr(lnk.regAddr), .regWdata(lnk.regWdata), .regRdata(lnk.regRdata),
        .globalIrqEn(lnk.globalIrqEn), .irqRxComplete(lnk.irqRxComplete),
        .irqTxComplete(lnk.irqTxComplete), .irqTxEmpty(lnk.irqTxEmpty));
    initial forever #12.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] irqExp(input logic rx);
        return {6'h00, 1'b1, rx};
    endfunction
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cmd(input logic [1:0] op, input logic [2:0] idx, input logic [8:0] d);
        apb(1'b1, spf_pkg::APB_CMD, {14'h0, op, 1'b0, idx, 3'h0, d});
        do apb(1'b0, spf_pkg::APB_STAT, 32'h0); while (rdv[0] !== 1'b0);
    endtask
    task automatic stop_test();
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        cmd(spf_pkg::OP_READ, spf_pkg::REG_STATUS_A, 9'h000);
        check("status after reset", rdv[15:8], 8'h20);
        apb(1'b1, spf_pkg::APB_GIE, 32'h1);
        cmd(spf_pkg::OP_WRITE, spf_pkg::REG_CONTROL_B, 9'h020);
        apb(1'b0, spf_pkg::APB_STAT, 32'h0);
        check("empty irq on", {5'h00, rdv[18:16]}, 8'h04);
        apb(1'b1, spf_pkg::APB_GIE, 32'h0);
        repeat (3) apb(1'b0, spf_pkg::APB_STAT, 32'h0);
        check("empty irq off", {5'h00, rdv[18:16]}, 8'h00);
        cmd(spf_pkg::OP_WRITE, spf_pkg::REG_CONTROL_C, 9'h040);
        cmd(spf_pkg::OP_WRITE, spf_pkg::REG_STATUS_A, 9'h03f);
        cmd(spf_pkg::OP_READ, spf_pkg::REG_STATUS_A, 9'h000);
        check("status masked", rdv[15:8], 8'h21);
        cmd(spf_pkg::OP_WRITE, spf_pkg::REG_CONTROL_C, 9'h000);
        cmd(spf_pkg::OP_WRITE, spf_pkg::REG_BAUD_LOW, 9'h000);
        cmd(spf_pkg::OP_WRITE, spf_pkg::REG_CONTROL_B, 9'h0dc);
        apb(1'b1, spf_pkg::APB_GIE, 32'h1);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            cmd(spf_pkg::OP_SEND, 3'h0, {i[0], seed[7:0]});
            repeat (220) @(posedge clk);
            apb(1'b0, spf_pkg::APB_STAT, 32'h0);
            check("irq after frame", {5'h00, rdv[18:16]}, irqExp(i[0]));
            if (i[0]) begin
                cmd(spf_pkg::OP_READ, spf_pkg::REG_DATA, 9'h000);
                check("looped data", rdv[15:8], seed[7:0]);
            end
        end
        cmd(spf_pkg::OP_WRITE, spf_pkg::REG_STATUS_A, 9'h003);
        cmd(spf_pkg::OP_SEND, 3'h0, 9'h1a5);
        repeat (120) @(posedge clk);
        apb(1'b0, spf_pkg::APB_STAT, 32'h0);
        check("fast frame irq", {5'h00, rdv[18:16]}, irqExp(1'b1));
        cmd(spf_pkg::OP_READ, spf_pkg::REG_DATA, 9'h000);
        check("fast data", rdv[15:8], 8'ha5);
        stop_test();
    end
endmodule // test_serial_port_flags_and_control
